// ---- rtl/itxf_defs.vh ----
// itxf_defs.vh: offsets, field positions, reset values and timing counts
// of the transmit data path; assumes inclusion by bare name.
`ifndef ITXF_DEFS_VH
`define ITXF_DEFS_VH

// register byte offsets on the 32-bit bus
`define ITXF_OFF_DATA 8'h00
`define ITXF_OFF_CTRL 8'h04
`define ITXF_OFF_MODE 8'h08
`define ITXF_OFF_PERIOD 8'h0C
`define ITXF_OFF_STAT 8'h10
`define ITXF_OFF_MASK 8'h14

// control register fields
`define ITXF_CTRL_EN 14
`define ITXF_CTRL_RUN 13
`define ITXF_CTRL_LVL_HI 12
`define ITXF_CTRL_LVL_LO 8
`define ITXF_CTRL_FLAG 7
`define ITXF_CTRL_CLR 6
`define ITXF_CTRL_IEN 5
`define ITXF_CTRL_THR_HI 4
`define ITXF_CTRL_THR_LO 0

// event bits of the status and mask registers
`define ITXF_EV_DONE 0
`define ITXF_EV_OVFL 1
`define ITXF_EV_FLAG 2
`define ITXF_EV_W 3

// reset values
`define ITXF_RST_DATA 8'h00
`define ITXF_RST_THR 5'h00
`define ITXF_RST_BPB 3'h0
`define ITXF_RST_MASK 3'h0

// bit period: time in ns and derived count of 100 MHz cycles
`define ITXF_CLK_NS 10
`define ITXF_BIT_NS 10000
`define ITXF_RST_PERIOD (`ITXF_BIT_NS / `ITXF_CLK_NS)

// bus responses
`define ITXF_RESP_OKAY 2'h0
`define ITXF_RESP_SLVERR 2'h2

`endif

// ---- rtl/itxf_fifo.v ----
// itxf_fifo.v: first-in first-out byte queue with fill level.
// assumes one clock; clear is synchronous and overrides push and pop.
`timescale 1ns/1ps

module itxf_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clock, // module clock
    input wire resetn, // asynchronous reset, active low
    input wire clear, // hold pointers and level at zero
    input wire in_valid, // push request
    input wire [WIDTH-1:0] in_data, // byte to push
    output wire in_ready, // room for one more entry
    output wire out_valid, // oldest entry present
    output wire [WIDTH-1:0] out_data, // oldest entry
    input wire out_ready, // pop the oldest entry
    output wire [AW:0] level // number of entries held
);

reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW-1:0] wr_ptr_reg;
reg [AW-1:0] rd_ptr_reg;
reg [AW:0] count_reg;
wire push;
wire pop;

////////////////////////////////////////////////////////////////////////////
// handshakes
assign in_ready = (count_reg != DEPTH[AW:0]);
assign out_valid = (count_reg != {(AW+1){1'b0}});
assign out_data = mem[rd_ptr_reg];
assign level = count_reg;
assign push = in_valid & in_ready & ~clear; // full push dropped
assign pop = out_valid & out_ready & ~clear;

////////////////////////////////////////////////////////////////////////////
// storage written at the tail
always @(posedge clock) begin
    if (push) begin
        mem[wr_ptr_reg] <= in_data;
    end
end

////////////////////////////////////////////////////////////////////////////
// pointers and count
always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
        wr_ptr_reg <= {AW{1'b0}};
        rd_ptr_reg <= {AW{1'b0}};
        count_reg <= {(AW+1){1'b0}};
    end else if (clear) begin
        wr_ptr_reg <= {AW{1'b0}};
        rd_ptr_reg <= {AW{1'b0}};
        count_reg <= {(AW+1){1'b0}};
    end else begin
        if (push) begin
            wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
        end
        if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
        end
        if (push & ~pop) begin
            count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
        end else if (pop & ~push) begin
            count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
        end
    end
end

endmodule // itxf_fifo

// ---- rtl/itxf_top.v ----
// itxf_top.v: transmit data register, optional transmit queue and
// serialiser of a two-wire serial controller, with an AXI4-Lite slave.
// assumes one clock, a well-behaved AXI4-Lite master and an open-drain
// data pad resolved outside from sda_out and sda_oe.
`timescale 1ns/1ps
`include "itxf_defs.vh"

module itxf_top #(
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clock, // module clock, 100 MHz
    input wire resetn, // asynchronous reset, active low
    input wire [7:0] s_axi_awaddr, // write address
    input wire s_axi_awvalid, // write address valid
    output reg s_axi_awready, // write address ready
    input wire [31:0] s_axi_wdata, // write data
    input wire [3:0] s_axi_wstrb, // write byte lanes
    input wire s_axi_wvalid, // write data valid
    output reg s_axi_wready, // write data ready
    output reg [1:0] s_axi_bresp, // write response
    output reg s_axi_bvalid, // write response valid
    input wire s_axi_bready, // write response ready
    input wire [7:0] s_axi_araddr, // read address
    input wire s_axi_arvalid, // read address valid
    output reg s_axi_arready, // read address ready
    output reg [31:0] s_axi_rdata, // read data
    output reg [1:0] s_axi_rresp, // read response
    output reg s_axi_rvalid, // read data valid
    input wire s_axi_rready, // read data ready
    output reg sda_out, // serial data bit level
    output reg sda_oe, // high while the data pin is driven
    output reg tx_busy, // a byte is being shifted out
    output reg tx_fifo_irq, // queue interrupt request
    output reg irq // unmasked event pending
);

localparam ST_IDLE = 1'b0;
localparam ST_SHIFT = 1'b1;
localparam [31:0] RST_PERIOD_W = `ITXF_RST_PERIOD;

// width of a byte: field value zero selects eight bits
function [3:0] byte_bits;
    input [2:0] bpb;
    byte_bits = (bpb == 3'h0) ? 4'h8 : {1'b0, bpb};
endfunction

// move a right-justified byte so its first bit sits at bit 7
function [7:0] align_byte;
    input [7:0] data;
    input [2:0] bpb;
    align_byte = data << (4'h8 - byte_bits(bpb));
endfunction

reg [7:0] tx_data_reg, tx_shift_reg, aw_addr_reg;
reg hold_full_reg, fifo_mode_enable_reg, tx_fifo_run_reg, state_reg;
reg tx_fifo_irq_flag_reg, tx_fifo_irq_enable_reg, aw_held_reg, w_held_reg;
reg [4:0] tx_fifo_irq_threshold_reg;
reg [2:0] bits_per_byte_reg;
reg [15:0] bit_period_reg, div_cnt_reg;
reg [`ITXF_EV_W-1:0] status_reg, mask_reg;
reg [31:0] w_data_reg, rd_value;
reg [3:0] w_strb_reg, bits_left_reg;
reg rd_ok;
wire fifo_active, wr_fire, wr_data, wr_ctrl, rd_fire, fifo_push;
wire fifo_in_ready, fifo_out_valid, load_fifo, load_hold, bit_tick;
wire last_bit, done_event, ovfl_event, flag_cond, flag_next;
wire [AW:0] tx_fifo_level;
wire [7:0] fifo_out_data, load_aligned;
wire [`ITXF_EV_W-1:0] events, status_next;
wire [15:0] ctrl_view;

////////////////////////////////////////////////////////////////////////////
// write decode
assign fifo_active = fifo_mode_enable_reg & tx_fifo_run_reg;
assign wr_fire = aw_held_reg & w_held_reg & ~s_axi_bvalid;
assign wr_data = wr_fire & (aw_addr_reg == `ITXF_OFF_DATA) & w_strb_reg[0];
assign wr_ctrl = wr_fire & (aw_addr_reg == `ITXF_OFF_CTRL);
assign rd_fire = s_axi_arvalid & s_axi_arready;
assign fifo_push = wr_data & fifo_active;
assign ovfl_event = fifo_push & ~fifo_in_ready;

////////////////////////////////////////////////////////////////////////////
// transmit queue, cleared while the run bit is low
itxf_fifo #(
    .WIDTH(8),
    .DEPTH(DEPTH),
    .AW(AW)
) u_fifo (
    .clock(clock),
    .resetn(resetn),
    .clear(~tx_fifo_run_reg),
    .in_valid(fifo_push),
    .in_data(w_data_reg[7:0]), // held word, master may have moved on
    .in_ready(fifo_in_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out_data),
    .out_ready(load_fifo),
    .level(tx_fifo_level)
);
////////////////////////////////////////////////////////////////////////////
// shift register loading and bit-period divider
assign load_fifo = (state_reg == ST_IDLE) & fifo_active &
    fifo_out_valid;
assign load_hold = (state_reg == ST_IDLE) & ~fifo_mode_enable_reg &
    hold_full_reg;
assign load_aligned = align_byte(load_fifo ? fifo_out_data : tx_data_reg,
    bits_per_byte_reg);
assign bit_tick = (state_reg == ST_SHIFT) &
    ({1'b0, div_cnt_reg} + 17'h00001 >= {1'b0, bit_period_reg});
assign last_bit = (bits_left_reg == 4'h1);
assign done_event = bit_tick & last_bit;
////////////////////////////////////////////////////////////////////////////
// queue flag: a standing condition wins over a clear
assign flag_cond = fifo_active &
    ({1'b0, tx_fifo_level} <= {1'b0, tx_fifo_irq_threshold_reg});
assign flag_next = flag_cond ? 1'b1 :
    ((wr_ctrl & w_strb_reg[0] & w_data_reg[`ITXF_CTRL_CLR]) ? 1'b0 :
    tx_fifo_irq_flag_reg);
assign events = {flag_next & ~tx_fifo_irq_flag_reg, ovfl_event,
    done_event};
assign status_next = events |
    ((rd_fire & ({s_axi_araddr[7:2], 2'b00} == `ITXF_OFF_STAT)) ?
    {`ITXF_EV_W{1'b0}} : status_reg);

// control register view; reserved bit 15 and clear bit read zero
assign ctrl_view = {1'b0, fifo_mode_enable_reg, tx_fifo_run_reg,
    tx_fifo_level, tx_fifo_irq_flag_reg, 1'b0, tx_fifo_irq_enable_reg,
    tx_fifo_irq_threshold_reg};

////////////////////////////////////////////////////////////////////////////
// write channel capture and response
always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `ITXF_RESP_OKAY;
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        aw_addr_reg <= 8'h00;
        w_data_reg <= 32'h00000000;
        w_strb_reg <= 4'h0;
    end else begin
        if (s_axi_awvalid & s_axi_awready) begin
            aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
            aw_held_reg <= 1'b1;
            s_axi_awready <= 1'b0;
        end
        if (s_axi_wvalid & s_axi_wready) begin
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
            w_held_reg <= 1'b1;
            s_axi_wready <= 1'b0;
        end
        if (wr_fire) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr_reg > `ITXF_OFF_MASK) ?
                `ITXF_RESP_SLVERR : `ITXF_RESP_OKAY;
        end
        if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end
    end
end
////////////////////////////////////////////////////////////////////////////
// read data mux
always @* begin
    rd_value = 32'h00000000;
    rd_ok = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
        `ITXF_OFF_DATA: rd_value = {24'h000000, tx_data_reg};
        `ITXF_OFF_CTRL: rd_value = {16'h0000, ctrl_view};
        `ITXF_OFF_MODE: rd_value = {29'h00000000, bits_per_byte_reg};
        `ITXF_OFF_PERIOD: rd_value = {16'h0000, bit_period_reg};
        `ITXF_OFF_STAT: rd_value = {29'h00000000, status_reg};
        `ITXF_OFF_MASK: rd_value = {29'h00000000, mask_reg};
        default: rd_ok = 1'b0;
    endcase
end

// read channel
always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `ITXF_RESP_OKAY;
    end else begin
        if (rd_fire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_value;
            s_axi_rresp <= rd_ok ? `ITXF_RESP_OKAY : `ITXF_RESP_SLVERR;
        end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
end
////////////////////////////////////////////////////////////////////////////
// software registers
always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
        tx_data_reg <= `ITXF_RST_DATA;
        hold_full_reg <= 1'b0;
        fifo_mode_enable_reg <= 1'b0;
        tx_fifo_run_reg <= 1'b0;
        tx_fifo_irq_enable_reg <= 1'b0;
        tx_fifo_irq_threshold_reg <= `ITXF_RST_THR;
        bits_per_byte_reg <= `ITXF_RST_BPB;
        bit_period_reg <= RST_PERIOD_W[15:0];
        mask_reg <= `ITXF_RST_MASK;
    end else begin
        if (load_hold) begin
            hold_full_reg <= 1'b0;
        end
        // data write: low lane only, upper lanes dropped
        if (wr_data) begin
            tx_data_reg <= w_data_reg[7:0];
            if (!fifo_mode_enable_reg) begin
                hold_full_reg <= 1'b1;
            end
        end
        if (wr_ctrl & w_strb_reg[1]) begin
            fifo_mode_enable_reg <= w_data_reg[`ITXF_CTRL_EN];
            tx_fifo_run_reg <= w_data_reg[`ITXF_CTRL_RUN];
        end
        if (wr_ctrl & w_strb_reg[0]) begin
            tx_fifo_irq_enable_reg <= w_data_reg[`ITXF_CTRL_IEN];
            tx_fifo_irq_threshold_reg <=
                w_data_reg[`ITXF_CTRL_THR_HI:`ITXF_CTRL_THR_LO];
        end
        if (wr_fire & (aw_addr_reg == `ITXF_OFF_MODE) & w_strb_reg[0]) begin
            bits_per_byte_reg <= w_data_reg[2:0];
        end
        if (wr_fire & (aw_addr_reg == `ITXF_OFF_PERIOD)) begin
            if (w_strb_reg[0]) begin
                bit_period_reg[7:0] <= w_data_reg[7:0];
            end
            if (w_strb_reg[1]) begin
                bit_period_reg[15:8] <= w_data_reg[15:8];
            end
        end
        if (wr_fire & (aw_addr_reg == `ITXF_OFF_MASK) & w_strb_reg[0]) begin
            mask_reg <= w_data_reg[`ITXF_EV_W-1:0];
        end
    end
end
////////////////////////////////////////////////////////////////////////////
// flags, events and interrupt outputs
always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
        tx_fifo_irq_flag_reg <= 1'b0;
        status_reg <= {`ITXF_EV_W{1'b0}};
        tx_fifo_irq <= 1'b0;
        irq <= 1'b0;
    end else begin
        tx_fifo_irq_flag_reg <= flag_next;
        status_reg <= status_next;
        tx_fifo_irq <= flag_next & tx_fifo_irq_enable_reg;
        irq <= |(status_next & mask_reg);
    end
end
////////////////////////////////////////////////////////////////////////////
// serialiser: first bit is the top bit of the byte width
always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
        state_reg <= ST_IDLE;
        tx_shift_reg <= 8'h00;
        bits_left_reg <= 4'h0;
        div_cnt_reg <= 16'h0000;
        sda_out <= 1'b1;
        sda_oe <= 1'b0;
        tx_busy <= 1'b0;
    end else begin
        case (state_reg)
            ST_IDLE: begin
                if (load_fifo | load_hold) begin
                    tx_shift_reg <= load_aligned;
                    sda_out <= load_aligned[7];
                    bits_left_reg <= byte_bits(bits_per_byte_reg);
                    div_cnt_reg <= 16'h0000;
                    sda_oe <= 1'b1;
                    tx_busy <= 1'b1;
                    state_reg <= ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (bit_tick) begin
                    div_cnt_reg <= 16'h0000;
                    if (last_bit) begin
                        sda_out <= 1'b1;
                        sda_oe <= 1'b0;
                        tx_busy <= 1'b0;
                        state_reg <= ST_IDLE;
                    end else begin
                        tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
                        sda_out <= tx_shift_reg[6];
                        bits_left_reg <= bits_left_reg - 4'h1;
                    end
                end else begin
                    div_cnt_reg <= div_cnt_reg + 16'h0001;
                end
            end
            default: begin
                state_reg <= ST_IDLE;
            end
        endcase
    end
end

endmodule // itxf_top

// ---- rtl/note_end.v ----
`timescale 1ns/1ps
// intentionally empty

// ---- verification/itxf_cpu_model.sv ----
// itxf_cpu_model.sv: software side of the block, an axi4-lite master
// with one write and one read task; assumes one shared module clock.
`timescale 1ns/1ps
module itxf_cpu_model (
    input logic clock, // module clock
    output logic [7:0] s_axi_awaddr, // write address
    output logic s_axi_awvalid, // write address valid
    input logic s_axi_awready, // write address ready
    output logic [31:0] s_axi_wdata, // write data
    output logic [3:0] s_axi_wstrb, // write lanes
    output logic s_axi_wvalid, // write data valid
    input logic s_axi_wready, // write data ready
    input logic [1:0] s_axi_bresp, // write response
    input logic s_axi_bvalid, // response valid
    output logic s_axi_bready, // response ready
    output logic [7:0] s_axi_araddr, // read address
    output logic s_axi_arvalid, // read address valid
    input logic s_axi_arready, // read address ready
    input logic [31:0] s_axi_rdata, // read data
    input logic [1:0] s_axi_rresp, // read response
    input logic s_axi_rvalid, // read data valid
    output logic s_axi_rready // read data ready
);
////////////////////////////////////////////////////////////////////////
// idle bus at time zero
initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = 45'h0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr} = 10'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
end
// one write; each channel released at its own handshake
task automatic wr(input logic [7:0] a, input logic [31:0] d,
    output logic [1:0] r);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    forever begin
        @(posedge clock);
        if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
        if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
        if (s_axi_bvalid && s_axi_bready) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'h0;
            break;
        end
    end
endtask
// one read; data taken at the rvalid edge
task automatic rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    forever begin
        @(posedge clock);
        if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
        if (s_axi_rvalid && s_axi_rready) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'h0;
            break;
        end
    end
endtask
endmodule // itxf_cpu_model

// ---- verification/itxf_top_asserts.sv ----
// itxf_top_asserts.sv: port checker of the transmit data path;
// assumes it is bound into itxf_top and sees only its ports.
`timescale 1ns/1ps
module itxf_top_asserts (
    input logic clock, // module clock
    input logic resetn, // reset, active low
    input logic s_axi_awvalid, // write address valid
    input logic s_axi_awready, // write address ready
    input logic s_axi_wvalid, // write data valid
    input logic s_axi_wready, // write data ready
    input logic s_axi_bvalid, // response valid
    input logic s_axi_bready, // response ready
    input logic s_axi_arvalid, // read address valid
    input logic s_axi_arready, // read address ready
    input logic s_axi_rvalid, // read data valid
    input logic sda_out, // serial bit
    input logic sda_oe, // pin driven
    input logic tx_busy // byte shifting
);
default clocking @(posedge clock); endclocking
default disable iff (!resetn);
////////////////////////////////////////////////////////////////////////
// write taken on both channels, then the answer within two edges
sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
endsequence
sequence resp_soon;
    ##[1:2] s_axi_bvalid;
endsequence
write_resp_a: assert property (wr_take |-> resp_soon)
    else $error("write response late");
aw_block_a: assert property (s_axi_awvalid && s_axi_awready |=>
    !s_axi_awready) else $error("write address taken twice");
ready_back_a: assert property (s_axi_bvalid && s_axi_bready |=>
    s_axi_awready && s_axi_wready) else $error("readies stuck");
read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read data late");
ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during answer");
pin_drive_a: assert property (sda_oe == tx_busy)
    else $error("pin enable and busy differ");
idle_level_a: assert property (!sda_oe |-> sda_out)
    else $error("data line low while idle");
load_gap_a: assert property ($fell(tx_busy) |-> !sda_oe && sda_out)
    else $error("line not released at byte end");
bit_steady_a: assert property ($changed(sda_out) |->
    tx_busy || $past(tx_busy)) else $error("bit moved outside byte");
endmodule // itxf_top_asserts
bind itxf_top itxf_top_asserts i_itxf_top_asserts (.clock(clock),
    .resetn(resetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .sda_out(sda_out), .sda_oe(sda_oe), .tx_busy(tx_busy));

// ---- verification/itxf_test.sv ----
// itxf_test.sv: self-checking bench of the transmit data path;
// assumes the design header and the software model are compiled first.
`timescale 1ns/1ps
`include "itxf_defs.vh"
module itxf_test;
logic clock, resetn, awv, awr, wv, wr_, bv, br, arv, arr, rv, rr;
logic sda_out, sda_oe, tx_busy, tx_fifo_irq, irq;
logic [7:0] awa, ara, sh;
logic [31:0] wd, rdat, d;
logic [3:0] ws;
logic [1:0] bresp, rresp, r;
int failures = 0, checked = 0, per = 1000, cnt = 0;
int q_n[$];
logic [7:0] q_v[$];
itxf_top i_itxf_top (.clock(clock), .resetn(resetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .sda_out(sda_out), .sda_oe(sda_oe),
    .tx_busy(tx_busy), .tx_fifo_irq(tx_fifo_irq), .irq(irq));
itxf_cpu_model i_itxf_cpu_model (.clock(clock), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr));
////////////////////////////////////////////////////////////////////////
// clock and serial monitor: one sample at the end of each bit
initial begin
    clock = 1'h0;
    forever #5 clock = ~clock;
end
always @(posedge clock) begin
    if (sda_oe === 1'h1) begin
        if (cnt % per == per - 1) sh = {sh[6:0], sda_out};
        cnt++;
    end else if (cnt != 0) begin
        q_n.push_back(cnt);
        q_v.push_back(sh);
        cnt = 0;
    end
end
////////////////////////////////////////////////////////////////////////
task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
        failures++;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
endtask
task wreg(input logic [7:0] a, input logic [31:0] v);
    i_itxf_cpu_model.wr(a, v, r);
endtask
task rreg(input logic [7:0] a);
    i_itxf_cpu_model.rd(a, d, r);
endtask
// wait for one finished byte and judge its length and value
task expect_byte(input int n, input logic [7:0] v);
    int k;
    for (k = 0; k < 3000 && q_n.size() == 0; k++) @(posedge clock);
    chk(q_n.size(), 1);
    if (q_n.size() != 0) begin
        chk(q_n.pop_front(), n * per);
        chk(q_v.pop_front() & ((16'h1 << n) - 1), v);
    end
endtask
task give_verdict;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
endtask
////////////////////////////////////////////////////////////////////////
// reset values and an unmapped place
task t_reset;
    rreg(`ITXF_OFF_DATA); chk(d, 32'h0);
    rreg(`ITXF_OFF_CTRL); chk(d, 32'h0);
    rreg(`ITXF_OFF_PERIOD); chk(d, `ITXF_RST_PERIOD);
    rreg(`ITXF_OFF_MASK); chk(d, 32'h0);
    rreg(`ITXF_OFF_MODE); chk(d, 32'h0); chk(r, `ITXF_RESP_OKAY);
    wreg(8'h40, 32'h1); chk(r, `ITXF_RESP_SLVERR);
    rreg(8'h40); chk(r, `ITXF_RESP_SLVERR);
endtask
// direct path: widths 8, 3, 1 and 7, then the done event through the interrupt
task t_shift;
    logic [2:0] code[4] = '{3'h0, 3'h3, 3'h1, 3'h7};
    logic [7:0] val[4] = '{8'hA5, 8'h05, 8'h01, 8'h2A};
    int i;
    per = 2;
    wreg(`ITXF_OFF_PERIOD, 32'h2);
    wreg(`ITXF_OFF_MASK, 32'h1);
    for (i = 0; i < 4; i++) begin
        wreg(`ITXF_OFF_MODE, code[i]); chk(r, `ITXF_RESP_OKAY);
        wreg(`ITXF_OFF_DATA, 32'hFFFF_FF00 | val[i]);
        rreg(`ITXF_OFF_DATA); chk(d, val[i]);
        expect_byte(code[i] == 3'h0 ? 8 : code[i], val[i]);
        chk(irq, 1'h1);
        rreg(`ITXF_OFF_STAT); chk(d, 32'h1);
        chk(irq, 1'h0);
    end
endtask
// queue: startup flag, enable, fill past full, clear, drain in order
task t_fifo;
    int i;
    per = 40;
    wreg(`ITXF_OFF_PERIOD, 32'h28);
    wreg(`ITXF_OFF_MODE, 32'h0);
    wreg(`ITXF_OFF_MASK, 32'h7);
    rreg(`ITXF_OFF_STAT);
    wreg(`ITXF_OFF_CTRL, 32'h6000);
    rreg(`ITXF_OFF_CTRL); chk(d, 32'h6080);
    chk(tx_fifo_irq, 1'h0);
    wreg(`ITXF_OFF_CTRL, 32'h6020);
    repeat (2) @(posedge clock);
    chk(tx_fifo_irq, 1'h1);
    wreg(`ITXF_OFF_CTRL, 32'h6040);
    rreg(`ITXF_OFF_CTRL); chk(d, 32'h6080);
    chk(tx_fifo_irq, 1'h0);
    rreg(`ITXF_OFF_STAT); chk(d, 32'h4);
    chk(irq, 1'h0);
    for (i = 0; i < 18; i++) wreg(`ITXF_OFF_DATA, 32'h10 + i);
    rreg(`ITXF_OFF_CTRL); chk(d, 32'h7080);
    chk(irq, 1'h1);
    rreg(`ITXF_OFF_STAT); chk(d[1], 1'h1);
    wreg(`ITXF_OFF_CTRL, 32'hE040);
    rreg(`ITXF_OFF_CTRL); chk(d, 32'h7000);
    for (i = 0; i < 17; i++) expect_byte(8, 8'h10 + i);
    rreg(`ITXF_OFF_CTRL); chk(d, 32'h6080);
    wreg(`ITXF_OFF_CTRL, 32'h4000);
    wreg(`ITXF_OFF_DATA, 32'h77);
    repeat (10) @(posedge clock);
    chk(sda_oe, 1'h0);
    rreg(`ITXF_OFF_CTRL); chk(d, 32'h4080);
endtask
////////////////////////////////////////////////////////////////////////
// main sequence and watchdog
initial begin
    resetn = 1'h0;
    repeat (16) @(posedge clock);
    resetn <= 1'h1;
    t_reset;
    t_shift;
    t_fifo;
    give_verdict;
end
initial begin
    repeat (60000) @(posedge clock);
    failures++;
    give_verdict;
end
endmodule // itxf_test
